// >>> hw/pex_pkg.sv
// Shared constants and types for the serial-bus eight-bit port expander.
// Assumes one system clock domain and one bus sampling clock domain.
package pex_pkg;

   // ---------------------------------------------------------------
   // Basic widths and types
   // ---------------------------------------------------------------
   localparam int PORT_W = 8;
   typedef logic [PORT_W-1:0] pex_byte_t;
   typedef logic [1:0]        pex_ptr_t;
   typedef logic [3:0]        pex_cnt_t;

   // ---------------------------------------------------------------
   // Register pointer codes (low two bits of the command byte)
   // ---------------------------------------------------------------
   localparam pex_ptr_t REG_INPUT_LEVELS = 2'h0;
   localparam pex_ptr_t REG_OUTPUT_LATCH = 2'h1;
   localparam pex_ptr_t REG_POL_INVERT   = 2'h2;
   localparam pex_ptr_t REG_PIN_DIR      = 2'h3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam pex_byte_t RST_OUTPUT_LATCH = 8'hff;
   localparam pex_byte_t RST_POL_INVERT   = 8'h00;
   localparam pex_byte_t RST_PIN_DIR      = 8'hff;
   localparam pex_ptr_t  RST_POINTER      = 2'h0;

   // ---------------------------------------------------------------
   // Bus framing
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_FIXED    = 4'h4;
   localparam pex_cnt_t   BITS_PER_BYTE = 4'h8;
   localparam pex_cnt_t   LAST_TX_BIT   = 4'h7;

   // Bus engine states and byte kinds
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK
   } pex_state_e;

   typedef enum logic [1:0] {
      K_ADDR, K_CMD, K_DATA
   } pex_kind_e;

   // Writable configuration carried to the pin domain
   typedef struct packed {
      pex_byte_t latch;
      pex_byte_t invert;
      pex_byte_t direction;
   } pex_cfg_s;

   localparam pex_cfg_s RST_CFG = '{
      latch:     RST_OUTPUT_LATCH,
      invert:    RST_POL_INVERT,
      direction: RST_PIN_DIR
   };

endpackage : pex_pkg

// >>> hw/pex_port_expander.sv
// Eight-bit port expander: serial-bus slave, four byte registers, alert.
// Assumes SCL/SDA and port pins are asynchronous; open-drain and
// push-pull pads are resolved outside from the out/oe pairs.
// How it works
// - SDA falling while SCL high is a start; device begins address reception.
// - Matching address is acknowledged by holding SDA low through the ack pulse.
// - One bit per SCL pulse; SDA change while SCL high is start or stop.
// - SDA rising while SCL high is a stop; device returns to idle.
// - Any number of eight-bit bytes, each followed by one ack slot.
// - Transmitter releases SDA before ack; acknowledger holds it low and stable.
// - As receiver the device acknowledges the command and every data byte.
// - On master nack the device releases SDA so a stop can follow.
// - Own address is 0100 then the three straps, giving 20h to 27h.
// - Address LSB one means read, zero means write.
// - First byte after an acknowledged write address loads the pointer.
// - Pointer low two bits select levels, latch, polarity, direction.
// - Pointer changes only in write transactions, never during reads.
// - Reads return the pointer-selected register until a new command byte.
// - Input register shows pin levels; writes to it are ignored.
// - Latch drives output pins only; reads return latch; resets to ones.
// - Polarity bit set inverts the reported level; resets to zeros.
// - Direction bit one is input, zero is output; resets to ones.
// - Reset puts all registers and the bus engine in defaults.
// - Alert asserts on any edge of an input pin, never output pins.
// - Alert clears on level return or at ack rise of an input read.
// - Write transactions accept unlimited data bytes to the selected register.
// - Read is command write, repeated start, then data until master nack.
`timescale 1ns/10ps
module pex_port_expander (
   input  wire logic              i_sys_clk,
   input  wire logic              i_reset,
   input  wire logic              i_link_clk,
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_sda_out,
   output logic                   o_sda_oe,
   input  wire logic              i_strap_addr_bit0,
   input  wire logic              i_strap_addr_bit1,
   input  wire logic              i_strap_addr_bit2,
   input  wire pex_pkg::pex_byte_t i_port_pin,
   output pex_pkg::pex_byte_t     o_port_out,
   output pex_pkg::pex_byte_t     o_port_oe,
   output logic                   o_alert_n_out,
   output logic                   o_alert_n_oe
);
   import pex_pkg::*;

   // ---------------------------------------------------------------
   // Register read mux
   // ---------------------------------------------------------------
   function automatic pex_byte_t read_mux(input pex_ptr_t ptr,
                                          input pex_byte_t lvl,
                                          input pex_cfg_s cfg);
      unique case (ptr)
         REG_INPUT_LEVELS: read_mux = lvl ^ cfg.invert;
         REG_OUTPUT_LATCH: read_mux = cfg.latch;
         REG_POL_INVERT:   read_mux = cfg.invert;
         REG_PIN_DIR:      read_mux = cfg.direction;
      endcase
   endfunction : read_mux

   // ---------------------------------------------------------------
   // Link domain: reset and input synchronisers
   // ---------------------------------------------------------------
   logic       lrst_s1_reg;
   logic       lrst_reg;
   logic       scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic       sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic [2:0] strap_s1_reg, strap_s2_reg;
   pex_byte_t  pin_l_s1_reg, pin_l_s2_reg;

   // Reset is carried into the link clock before use
   always_ff @(posedge i_link_clk) begin
      lrst_s1_reg <= i_reset;
      lrst_reg    <= lrst_s1_reg;
   end

   // Bus lines never clock logic; glitch-free edges need the third tap
   always_ff @(posedge i_link_clk) begin
      scl_s1_reg   <= i_scl;
      scl_s2_reg   <= scl_s1_reg;
      scl_d_reg    <= scl_s2_reg;
      sda_s1_reg   <= i_sda;
      sda_s2_reg   <= sda_s1_reg;
      sda_d_reg    <= sda_s2_reg;
      strap_s1_reg <= {i_strap_addr_bit2, i_strap_addr_bit1, i_strap_addr_bit0};
      strap_s2_reg <= strap_s1_reg;
      pin_l_s1_reg <= i_port_pin;
      pin_l_s2_reg <= pin_l_s1_reg;
   end

   // Edge and condition detection
   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise  = scl_s2_reg & ~scl_d_reg;
   assign scl_fall  = ~scl_s2_reg & scl_d_reg;
   assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign stop_det  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   // ---------------------------------------------------------------
   // Link domain: bus engine
   // ---------------------------------------------------------------
   pex_state_e state_reg;
   pex_kind_e  kind_reg;
   logic       rw_reg;
   pex_cnt_t   bit_cnt_reg;
   pex_byte_t  shift_reg;
   logic       nack_reg;
   logic       sda_oe_reg;
   logic       sda_out_reg;
   pex_ptr_t   ptr_reg;
   pex_cfg_s   cfg_reg;
   logic       clr_tgl_reg;
   logic       cfg_tgl_reg;
   logic       byte_done;
   logic       addr_match;
   pex_byte_t  rd_byte;

   assign byte_done  = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
   assign addr_match = (shift_reg[7:1] == {ADDR_FIXED, strap_s2_reg});
   assign rd_byte    = read_mux(ptr_reg, pin_l_s2_reg, cfg_reg);

   // Start and stop win over bit handling anywhere in a transfer
   always_ff @(posedge i_link_clk) begin
      if (lrst_reg) begin
         state_reg   <= ST_IDLE;
         kind_reg    <= K_ADDR;
         rw_reg      <= 1'b0;
         bit_cnt_reg <= '0;
         shift_reg   <= '0;
         nack_reg    <= 1'b0;
         sda_oe_reg  <= 1'b0;
      end else if (start_det) begin
         state_reg   <= ST_RX;
         kind_reg    <= K_ADDR;
         bit_cnt_reg <= '0;
         sda_oe_reg  <= 1'b0;
      end else if (stop_det) begin
         state_reg  <= ST_IDLE;
         sda_oe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise) begin
                  shift_reg   <= {shift_reg[6:0], sda_s2_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (byte_done) begin
                  if (kind_reg == K_ADDR && !addr_match) begin
                     state_reg <= ST_IDLE;
                  end else begin
                     state_reg  <= ST_RX_ACK;
                     sda_oe_reg <= 1'b1;
                     if (kind_reg == K_ADDR) begin
                        rw_reg <= shift_reg[0];
                     end
                  end
               end
            end
            ST_RX_ACK: begin
               // Held low through the whole high phase of the ack pulse
               if (scl_fall) begin
                  bit_cnt_reg <= '0;
                  if (kind_reg == K_ADDR && rw_reg) begin
                     state_reg  <= ST_TX;
                     shift_reg  <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                  end else begin
                     state_reg  <= ST_RX;
                     sda_oe_reg <= 1'b0;
                     kind_reg   <= (kind_reg == K_ADDR) ? K_CMD : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == LAST_TX_BIT) begin
                     state_reg  <= ST_TX_ACK;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     shift_reg   <= {shift_reg[6:0], 1'b0};
                     sda_oe_reg  <= ~shift_reg[6];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  nack_reg <= sda_s2_reg;
               end
               if (scl_fall) begin
                  bit_cnt_reg <= '0;
                  if (nack_reg) begin
                     state_reg  <= ST_IDLE;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     state_reg  <= ST_TX;
                     shift_reg  <= rd_byte;
                     sda_oe_reg <= ~rd_byte[7];
                  end
               end
            end
         endcase
      end
   end

   // Open-drain data line only ever pulls low
   always_ff @(posedge i_link_clk) begin
      sda_out_reg <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Link domain: pointer and writable registers
   // ---------------------------------------------------------------
   // Pointer moves only on a command byte, so reads cannot change it
   always_ff @(posedge i_link_clk) begin
      if (lrst_reg) begin
         ptr_reg <= RST_POINTER;
      end else if (byte_done && kind_reg == K_CMD) begin
         ptr_reg <= shift_reg[1:0];
      end
   end

   // Data bytes land when the ack slot opens
   always_ff @(posedge i_link_clk) begin
      if (lrst_reg) begin
         cfg_reg     <= RST_CFG;
         cfg_tgl_reg <= 1'b0;
      end else if (byte_done && kind_reg == K_DATA) begin
         cfg_tgl_reg <= ~cfg_tgl_reg;
         unique case (ptr_reg)
            REG_INPUT_LEVELS: cfg_reg <= cfg_reg;
            REG_OUTPUT_LATCH: cfg_reg.latch     <= shift_reg;
            REG_POL_INVERT:   cfg_reg.invert    <= shift_reg;
            REG_PIN_DIR:      cfg_reg.direction <= shift_reg;
         endcase
      end
   end

   // Toggle marks an input-register read at the ack rising edge
   always_ff @(posedge i_link_clk) begin
      if (lrst_reg) begin
         clr_tgl_reg <= 1'b0;
      end else if (state_reg == ST_TX_ACK && scl_rise && ptr_reg == REG_INPUT_LEVELS
                   && !start_det && !stop_det) begin
         clr_tgl_reg <= ~clr_tgl_reg;
      end
   end

   assign o_sda_out = sda_out_reg;
   assign o_sda_oe  = sda_oe_reg;

   // ---------------------------------------------------------------
   // System domain: crossings
   // ---------------------------------------------------------------
   // Config word is taken whole after its toggle crosses, so no bit skew
   pex_cfg_s  cfg_s2_reg;
   pex_byte_t pin_s1_reg, pin_s2_reg;
   logic      clr_s1_reg, clr_s2_reg, clr_s3_reg;
   logic      cfg_t1_reg, cfg_t2_reg, cfg_t3_reg;
   logic      clr_evt;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cfg_s2_reg <= RST_CFG;
      end else if (cfg_t2_reg ^ cfg_t3_reg) begin
         cfg_s2_reg <= cfg_reg;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      pin_s1_reg <= i_port_pin;
      pin_s2_reg <= pin_s1_reg;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         clr_s1_reg <= 1'b0;
         clr_s2_reg <= 1'b0;
         clr_s3_reg <= 1'b0;
         {cfg_t3_reg, cfg_t2_reg, cfg_t1_reg} <= 3'h0;
      end else begin
         clr_s1_reg <= clr_tgl_reg;
         clr_s2_reg <= clr_s1_reg;
         clr_s3_reg <= clr_s2_reg;
         {cfg_t3_reg, cfg_t2_reg, cfg_t1_reg} <= {cfg_t2_reg, cfg_t1_reg, cfg_tgl_reg};
      end
   end
   assign clr_evt = clr_s2_reg ^ clr_s3_reg;

   // ---------------------------------------------------------------
   // System domain: pin drive and alert
   // ---------------------------------------------------------------
   pex_byte_t port_out_reg, port_oe_reg, ref_reg;
   logic      alert_oe_reg, alert_out_reg;

   // Latch reaches only pins set as outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         port_out_reg <= RST_OUTPUT_LATCH;
         port_oe_reg  <= '0;
      end else begin
         port_out_reg <= cfg_s2_reg.latch;
         port_oe_reg  <= ~cfg_s2_reg.direction;
      end
   end

   // Reference level; a clear re-arms against the present pins
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || clr_evt) begin
         ref_reg <= pin_s2_reg;
      end
   end

   // Mismatch on input pins only; return to reference drops it again
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         alert_oe_reg  <= 1'b0;
         alert_out_reg <= 1'b0;
      end else begin
         alert_oe_reg  <= |((pin_s2_reg ^ ref_reg) & cfg_s2_reg.direction);
         alert_out_reg <= 1'b0;
      end
   end

   assign o_port_out    = port_out_reg;
   assign o_port_oe     = port_oe_reg;
   assign o_alert_n_out = alert_out_reg;
   assign o_alert_n_oe  = alert_oe_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_START_ADDR: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      start_det |=> (state_reg == ST_RX && kind_reg == K_ADDR && bit_cnt_reg == 4'h0))
      else $error("start not followed by address reception");

   AST_STOP_IDLE: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      stop_det && !start_det |=> (state_reg == ST_IDLE && !o_sda_oe))
      else $error("stop did not return to idle");

   AST_ADDR_ACK: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (byte_done && kind_reg == K_ADDR && addr_match && !start_det && !stop_det)
      |=> o_sda_oe && state_reg == ST_RX_ACK)
      else $error("own address not acknowledged");

   AST_ADDR_MISS: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (byte_done && kind_reg == K_ADDR && !addr_match && !start_det && !stop_det)
      |=> !o_sda_oe && state_reg == ST_IDLE)
      else $error("foreign address acknowledged");

   AST_ACK_HELD: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (state_reg == ST_RX_ACK) |-> o_sda_oe && !o_sda_out)
      else $error("ack slot not held low");

   AST_CMD_PTR: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (byte_done && kind_reg == K_CMD && !start_det && !stop_det)
      |=> ptr_reg == $past(shift_reg[1:0]))
      else $error("command byte not captured");

   AST_LATCH_WRITE: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (byte_done && kind_reg == K_DATA && ptr_reg == REG_OUTPUT_LATCH
       && !start_det && !stop_det) |=> cfg_reg.latch == $past(shift_reg))
      else $error("latch write not applied at ack");

   AST_NACK_RELEASE: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (state_reg == ST_TX_ACK && nack_reg && scl_fall && !start_det && !stop_det)
      |=> state_reg == ST_IDLE ##1 !o_sda_oe)
      else $error("device kept driving after nack");

   AST_READ_PTR_HOLD: assert property (@(posedge i_link_clk) disable iff (lrst_reg)
      (state_reg == ST_TX) |=> $stable(ptr_reg))
      else $error("pointer changed during read");

   AST_ALERT_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (clr_evt ##1 $stable(pin_s2_reg)) |=> !o_alert_n_oe)
      else $error("alert not cleared by input read");

   AST_OUT_NO_ALERT: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (cfg_s2_reg.direction == 8'h00) [*2] |=> !o_alert_n_oe)
      else $error("output pins raised alert");

   COV_WRITE: cover property (@(posedge i_link_clk) disable iff (lrst_reg)
      byte_done && kind_reg == K_DATA);
   COV_READ: cover property (@(posedge i_link_clk) disable iff (lrst_reg)
      state_reg == ST_TX_ACK && scl_rise && !sda_s2_reg);
   COV_NACK: cover property (@(posedge i_link_clk) disable iff (lrst_reg)
      state_reg == ST_TX_ACK && nack_reg && scl_fall);
   COV_ALERT: cover property (@(posedge i_sys_clk) disable iff (i_reset)
      $rose(o_alert_n_oe));

endmodule : pex_port_expander

// >>> bench/pex_bus_master.sv
// Behavioural two-wire bus master for the port expander bench.
// Assumes open-drain lines with pull-ups resolved in the bench.
`timescale 1ns/10ps
module pex_bus_master (
   output logic      o_scl_low,
   output logic      o_sda_low,
   input  wire logic i_sda
);
   // Quarter bit of 32 system clocks keeps edges on the bench grid
   localparam time QTR = 640ns;
   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end
   // Start or repeated start; only issued from idle or after an ack slot
   task automatic bus_start;
      o_sda_low = 1'b0; #QTR;
      o_scl_low = 1'b0; #QTR;
      o_sda_low = 1'b1; #QTR;
      o_scl_low = 1'b1; #QTR;
   endtask : bus_start
   // One bit: data moves only while clock is low, sampled mid-high
   task automatic bus_bit(input logic b, output logic s);
      o_sda_low = !b; #QTR;
      o_scl_low = 1'b0; #QTR;
      s = i_sda; #QTR;
      o_scl_low = 1'b1; #QTR;
   endtask : bus_bit
   // Byte out MSB first then one ack slot with the line released
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bus_bit(d[i], s);
      bus_bit(1'b1, s);
      ack = !s;
   endtask : send_byte
   // Byte in; the ack slot is pulled low only when ack is set
   task automatic recv_byte(output logic [7:0] d, input logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bus_bit(1'b1, d[i]);
      bus_bit(!ack, s);
   endtask : recv_byte
   // Stop: data rises while clock is high, then the bus idles high
   task automatic bus_stop;
      o_sda_low = 1'b1; #QTR;
      o_scl_low = 1'b0; #QTR;
      o_sda_low = 1'b0; #QTR;
   endtask : bus_stop
endmodule : pex_bus_master

// >>> bench/tb.sv
// Self-checking bench for the port expander.
// Assumes a bus master model drives clock and data as open-drain lines.
`timescale 1ns/10ps
module tb;
   import pex_pkg::*;
   logic       i_sys_clk, i_reset, i_link_clk, scl_low, sda_low, sda_oe, sda_o;
   logic       alert_oe, alert_o;
   logic [2:0] strap;
   pex_byte_t  ext_pin, port_out, port_oe, pin;
   int         num_errors, cmp_count, cycles;
   wire        scl = !scl_low;
   wire        sda = !sda_low & (!sda_oe | sda_o);
   // Driven pins follow the latch, others the outside world
   assign pin = (port_oe & port_out) | (~port_oe & ext_pin);
   pex_port_expander DUT (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_link_clk(i_link_clk),
      .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o), .o_sda_oe(sda_oe),
      .i_strap_addr_bit0(strap[0]), .i_strap_addr_bit1(strap[1]),
      .i_strap_addr_bit2(strap[2]), .i_port_pin(pin), .o_port_out(port_out),
      .o_port_oe(port_oe), .o_alert_n_out(alert_o), .o_alert_n_oe(alert_oe));
   pex_bus_master m (.o_scl_low(scl_low), .o_sda_low(sda_low), .i_sda(sda));
   // Clocks: link clock free running with an unrelated phase
   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = !i_sys_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #37;
      forever #62.5 i_link_clk = !i_link_clk;
   end
   // Hang guard; a full run needs roughly 60000 cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 80000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Start, own write address and command byte
   task automatic hdr(input logic [7:0] cmd);
      logic a;
      @(posedge i_sys_clk) #1;
      m.bus_start();
      m.send_byte({ADDR_FIXED, strap, 1'b0}, a);
      check("write address ack", a, 1'b1);
      m.send_byte(cmd, a);
      check("command ack", a, 1'b1);
   endtask : hdr
   task automatic wr(input logic [7:0] cmd, input pex_byte_t d0, input pex_byte_t d1);
      logic a;
      hdr(cmd);
      m.send_byte(d0, a);
      check("data ack", a, 1'b1);
      m.send_byte(d1, a);
      check("data ack", a, 1'b1);
      m.bus_stop();
   endtask : wr
   // Command write, repeated start, n bytes, last one unacknowledged
   task automatic rd(input logic [7:0] cmd, input pex_byte_t exp, input int n);
      logic a;
      pex_byte_t d;
      hdr(cmd);
      m.bus_start();
      m.send_byte({ADDR_FIXED, strap, 1'b1}, a);
      check("read address ack", a, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.recv_byte(d, i < n - 1);
         check("read data", d, exp);
      end
      m.bus_stop();
      check("data line released", sda_oe, 1'b0);
   endtask : rd
   // Each strap value answers at its own address; with strap 7 the foreign address 26h gets no ack
   task automatic t_address;
      logic a;
      for (int s = 0; s < 8; s++) begin
         strap = 3'(s);
         @(posedge i_sys_clk) #1;
         m.bus_start();
         m.send_byte({ADDR_FIXED, strap, 1'b0}, a);
         check("own address ack", a, 1'b1);
         m.bus_stop();
      end
      @(posedge i_sys_clk) #1;
      m.bus_start();
      m.send_byte({4'h4, 3'h6, 1'b0}, a);
      check("foreign address nack", a, 1'b0);
      m.bus_stop();
   endtask : t_address
   // Latch and direction writes; latch read back twice in one frame, direction once
   task automatic t_config;
      wr(8'h01, 8'h3c, 8'ha5);
      wr(8'hf3, 8'h00, 8'h0f);
      check("pin drive enables", port_oe, 8'hf0);
      check("pin drive levels", port_out, 8'ha5);
      check("no alert from outputs", alert_oe, 1'b0);
      rd(8'h01, 8'ha5, 2);
      rd(8'h03, 8'h0f, 1);
   endtask : t_config
   // Input edge raises alert; input read and level return clear it
   task automatic t_alert;
      @(posedge i_sys_clk) #1;
      ext_pin = 8'hfc;
      repeat (8) @(posedge i_sys_clk) #1;
      check("alert on input edge", alert_oe, 1'b1);
      check("alert line level", alert_o, 1'b0);
      rd(8'h00, 8'hac, 1);
      check("alert cleared by read", alert_oe, 1'b0);
      ext_pin = 8'hfd;
      repeat (8) @(posedge i_sys_clk) #1;
      check("alert again", alert_oe, 1'b1);
      ext_pin = 8'hfc;
      repeat (8) @(posedge i_sys_clk) #1;
      check("alert on level return", alert_oe, 1'b0);
   endtask : t_alert
   // Inversion applies to the read value; input register ignores writes
   task automatic t_invert;
      wr(8'h02, 8'h00, 8'h81);
      wr(8'h00, 8'h55, 8'h55);
      rd(8'h00, 8'h2d, 2);
   endtask : t_invert
   initial begin
      {num_errors, cmp_count, cycles} = '0;
      i_reset = 1'b1;
      strap = 3'h5;
      ext_pin = 8'hff;
      // Held past four link edges so both domains see it
      repeat (30) @(posedge i_sys_clk);
      #1 i_reset = 1'b0;
      repeat (60) @(posedge i_sys_clk);
      check("reset drive enables", port_oe, 8'h00);
      check("reset drive levels", port_out, 8'hff);
      check("reset alert", alert_oe, 1'b0);
      check("reset data line", sda_oe, 1'b0);
      check("data line pull level", sda_o, 1'b0);
      rd(8'h02, 8'h00, 1);
      t_address();
      t_config();
      t_alert();
      t_invert();
      print_verdict();
   end
endmodule : tb
